// file: adio_host_regs.sv
// Host-facing register block of the analog and digital I/O adapter
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Decode sixteen addresses at a configurable base using low four bits.
// - Write to offset 0 loads control byte and starts one conversion.
// - Conversion finish drives done flag, offset 2 bit 0, low.
// - Result low byte at offset 0, upper four bits at offset 1.
// - Control bits 7:6 select clock mode or standby/full power-down.
// - Control bit 5 selects internal six-clock or external acquisition.
// - Control bits 4:3 select span and polarity of input.
// - Control bits 2:0 select input channel 0 to 7.
// - Per-bit direction: zero input, one drives data bit out.
// - Port one direction at offset 4, data at offset 5.
// - Port two direction at offset 6, data at offset 7.
module adio_host_regs
    import adio_pkg::*;
#(
    parameter logic [9:0] BASE_ADDR = adio_pkg::BASE_DEFAULT
) (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire adio_pkg::adio_bus_t bus,
    output logic [7:0]              rdata,
    output logic                    rdataValid,
    input  wire logic               convDone,
    input  wire logic [11:0]        convResult,
    output adio_pkg::adio_conv_t    conv,
    input  wire logic [15:0]        pinIn,
    output logic [15:0]             pinOut,
    output logic [15:0]             pinOe
);
    import adio_pkg::*;

    // ==========================================================
    // Address decode
    logic              hit;
    logic [OFS_W-1:0]  ofs;
    logic              wrHit;
    logic              rdHit;
    assign hit   = bus.addr[ADDR_W-1:OFS_W] == BASE_ADDR[ADDR_W-1:OFS_W];
    assign ofs   = bus.addr[OFS_W-1:0];
    assign wrHit = hit && bus.wr;
    assign rdHit = hit && bus.rd;

    // ==========================================================
    // Converter control and status
    adio_ctrl_t  ctrl;
    logic [11:0] result;
    logic        doneN;
    logic        busy;

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
        end else if (wrHit && ofs == OFS_CONTROL) begin
            ctrl <= adio_ctrl_t'(bus.wdata);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            conv <= '0;
        end else begin
            conv.start <= wrHit && ofs == OFS_CONTROL;
            conv.internalClock <= ctrl.powerMode == PWR_INT_CLK ||
                (conv.internalClock && ctrl.powerMode[1]);
            conv.standbyPowerdown <= ctrl.powerMode == PWR_STANDBY;
            conv.fullPowerdown <= ctrl.powerMode == PWR_FULL;
            conv.externalAcq <= ctrl.acquisitionSelect;
            conv.span <= {ctrl.spanSelect, ctrl.polaritySelect};
            conv.channel <= ctrl.channelIndex;
        end
    end

    // Start wins over a finish landing in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            doneN  <= 1'b1;
            busy   <= 1'b0;
            result <= RESULT_RESET;
        end else if (wrHit && ofs == OFS_CONTROL) begin
            doneN <= 1'b1;
            busy  <= 1'b1;
        end else if (busy && convDone) begin
            doneN  <= 1'b0;
            busy   <= 1'b0;
            result <= convResult;
        end
    end

    // ==========================================================
    // Digital ports
    logic [7:0] dirReg  [2];
    logic [7:0] dataReg [2];
    logic [3:0] ofsDir  [2];
    logic [3:0] ofsData [2];
    assign ofsDir[0]  = OFS_P1_DIR;
    assign ofsDir[1]  = OFS_P2_DIR;
    assign ofsData[0] = OFS_P1_DATA;
    assign ofsData[1] = OFS_P2_DATA;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            always_ff @(posedge mclk) begin
                if (reset) begin
                    dirReg[p]  <= PORT_RESET;
                    dataReg[p] <= PORT_RESET;
                end else if (wrHit) begin
                    if (ofs == ofsDir[p]) dirReg[p] <= bus.wdata;
                    if (ofs == ofsData[p]) dataReg[p] <= bus.wdata;
                end
            end
            always_ff @(posedge mclk) begin
                if (reset) begin
                    pinOut[p*8 +: 8] <= PORT_RESET;
                    pinOe[p*8 +: 8]  <= PORT_RESET;
                end else begin
                    pinOut[p*8 +: 8] <= dataReg[p];
                    pinOe[p*8 +: 8]  <= dirReg[p];
                end
            end
        end
    endgenerate

    // Input bits show the pin, output bits show the latch
    function automatic logic [7:0] portView(input logic [7:0] d,
                                            input logic [7:0] o,
                                            input logic [7:0] i);
        portView = (d & o) | (~d & i);
    endfunction

    // ==========================================================
    // Read mux
    logic [7:0] next_rdata;
    always_comb begin
        case (ofs)
            OFS_RESULT_LO: next_rdata = result[7:0];
            OFS_RESULT_HI: next_rdata = {4'h0, result[11:8]};
            OFS_STATUS:    next_rdata = {7'h00, doneN};
            OFS_P1_DIR:    next_rdata = dirReg[0];
            OFS_P1_DATA:   next_rdata = portView(dirReg[0], dataReg[0], pinIn[7:0]);
            OFS_P2_DIR:    next_rdata = dirReg[1];
            OFS_P2_DATA:   next_rdata = portView(dirReg[1], dataReg[1], pinIn[15:8]);
            default:       next_rdata = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata      <= BYTE_ZERO;
            rdataValid <= 1'b0;
        end else begin
            rdata      <= rdHit ? next_rdata : BYTE_ZERO;
            rdataValid <= rdHit;
        end
    end

    // ==========================================================
    // Checks
    start_pulse_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_CONTROL |=> conv.start)
        else $error("control write did not start conversion");
    busy_flag_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_CONTROL |=> doneN)
        else $error("done flag not high after start");
    done_low_a: assert property (@(posedge mclk) disable iff (reset)
        busy && convDone && !(wrHit && ofs == OFS_CONTROL) |=> !doneN)
        else $error("done flag not low after finish");
    result_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !busy |=> $stable(result))
        else $error("result changed while idle");
    high_nibble_a: assert property (@(posedge mclk) disable iff (reset)
        rdHit && ofs == OFS_RESULT_HI |=> rdata[7:4] == 4'h0)
        else $error("unused result bits not zero");
    empty_read_a: assert property (@(posedge mclk) disable iff (reset)
        rdHit && ofs > OFS_P2_DATA |=> rdata == BYTE_ZERO)
        else $error("unmapped read not zero");
    full_pd_a: assert property (@(posedge mclk) disable iff (reset)
        ctrl.powerMode == PWR_FULL |=> conv.fullPowerdown && !conv.standbyPowerdown)
        else $error("power mode wrong");
    chan_sel_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> conv.channel == $past(ctrl.channelIndex))
        else $error("channel index wrong");
    dir_drive_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_P1_DIR ##1 !(wrHit && ofs == OFS_P1_DIR)
        |=> pinOe[7:0] == $past(bus.wdata, 2))
        else $error("port one direction not applied");
    one_data_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_P1_DATA ##1 !(wrHit && ofs == OFS_P1_DATA)
        |=> pinOut[7:0] == $past(bus.wdata, 2))
        else $error("port one data not applied");
    two_dir_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_P2_DIR ##1 !(wrHit && ofs == OFS_P2_DIR)
        |=> pinOe[15:8] == $past(bus.wdata, 2))
        else $error("port two direction not applied");
    two_data_a: assert property (@(posedge mclk) disable iff (reset)
        wrHit && ofs == OFS_P2_DATA ##1 !(wrHit && ofs == OFS_P2_DATA)
        |=> pinOut[15:8] == $past(bus.wdata, 2))
        else $error("port two data not applied");
    acq_sel_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> conv.externalAcq == $past(ctrl.acquisitionSelect))
        else $error("acquisition select wrong");
    span_sel_a: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> conv.span == $past({ctrl.spanSelect, ctrl.polaritySelect}))
        else $error("span select wrong");
    standby_pd_a: assert property (@(posedge mclk) disable iff (reset)
        ctrl.powerMode == PWR_STANDBY
        |=> conv.standbyPowerdown && !conv.fullPowerdown)
        else $error("standby mode wrong");
    int_clock_a: assert property (@(posedge mclk) disable iff (reset)
        ctrl.powerMode == PWR_INT_CLK |=> conv.internalClock)
        else $error("internal clock not selected");
    clock_hold_a: assert property (@(posedge mclk) disable iff (reset)
        ctrl.powerMode[1] |=> conv.internalClock == $past(conv.internalClock))
        else $error("clock mode changed in power-down");
    result_load_a: assert property (@(posedge mclk) disable iff (reset)
        busy && convDone && !(wrHit && ofs == OFS_CONTROL)
        |=> result == $past(convResult))
        else $error("result not captured at finish");
    status_read_a: assert property (@(posedge mclk) disable iff (reset)
        rdHit && ofs == OFS_STATUS |=> rdata == {7'h00, $past(doneN)})
        else $error("status read wrong");
    read_answer_a: assert property (@(posedge mclk) disable iff (reset)
        rdHit |=> rdataValid)
        else $error("window read not answered");
    idle_read_a: assert property (@(posedge mclk) disable iff (reset)
        !rdHit |=> !rdataValid && rdata == BYTE_ZERO)
        else $error("read answer without request");
    foreign_ignored_a: assert property (@(posedge mclk) disable iff (reset)
        bus.wr && !hit |=> $stable(ctrl) && !conv.start)
        else $error("write outside window took effect");

endmodule // adio_host_regs
`default_nettype wire

// file: adio_pkg.sv
// Package: register map, control fields and carrier types of the adapter register block
package adio_pkg;

    localparam int          ADDR_W        = 10;
    localparam int          OFS_W         = 4;
    localparam logic [3:0]  OFS_RESULT_LO = 4'h0;
    localparam logic [3:0]  OFS_CONTROL   = 4'h0;
    localparam logic [3:0]  OFS_RESULT_HI = 4'h1;
    localparam logic [3:0]  OFS_STATUS    = 4'h2;
    localparam logic [3:0]  OFS_P1_DIR    = 4'h4;
    localparam logic [3:0]  OFS_P1_DATA   = 4'h5;
    localparam logic [3:0]  OFS_P2_DIR    = 4'h6;
    localparam logic [3:0]  OFS_P2_DATA   = 4'h7;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  PORT_RESET    = 8'h00;
    localparam logic [11:0] RESULT_RESET  = 12'h000;
    localparam logic [9:0]  BASE_DEFAULT  = 10'h300;
    localparam logic [1:0]  PWR_EXT_CLK   = 2'h0;
    localparam logic [1:0]  PWR_INT_CLK   = 2'h1;
    localparam logic [1:0]  PWR_STANDBY   = 2'h2;
    localparam logic [1:0]  PWR_FULL      = 2'h3;
    localparam int          INT_ACQ_CLKS  = 6;

    // Converter control byte field layout
    typedef struct packed {
        logic [1:0] powerMode;        // high: power_mode_high
        logic       acquisitionSelect;
        logic       spanSelect;
        logic       polaritySelect;
        logic [2:0] channelIndex;
    } adio_ctrl_t;

    // Host bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              rd;
        logic              wr;
        logic [7:0]        wdata;
    } adio_bus_t;

    // Converter-facing signals
    typedef struct packed {
        logic       start;
        logic       internalClock;
        logic       standbyPowerdown;
        logic       fullPowerdown;
        logic       externalAcq;
        logic [1:0] span;
        logic [2:0] channel;
    } adio_conv_t;

endpackage

// file: adio_conv_model.sv
// Behavioural converter model answering the latest start after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module adio_conv_model
    import adio_pkg::*;
#(
    parameter int DLY = 10
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire adio_pkg::adio_conv_t conv,
    output logic                      convDone,
    output logic [11:0]               convResult
);
    int          cnt;
    logic [11:0] res;
    // ==========================================
    // Conversion timing
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 0;
        end else if (conv.start) begin
            cnt <= DLY;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign convDone = (cnt == 1);
    // Result valid only with the done strobe, inverted otherwise
    assign res = {1'b1, conv.channel, 5'h00, conv.channel};
    assign convResult = convDone ? res : ~res;
endmodule // adio_conv_model
`default_nettype wire

// file: tb_adio_host_regs.sv
// Self-checking bench for the host register block
`timescale 1ns/1ps
`default_nettype none
module tb_adio_host_regs;
    import adio_pkg::*;
    logic        mclk;
    logic        reset;
    adio_bus_t   bus;
    logic [7:0]  rdata;
    logic        rdataValid;
    logic        convDone;
    logic [11:0] convResult;
    adio_conv_t  conv;
    logic [15:0] pinIn;
    logic [15:0] pinOut;
    logic [15:0] pinOe;
    int          n_fail;
    int          samples_checked;
    logic        expInt;
    logic [7:0]  ctl;
    logic [7:0]  st;
    logic [3:0]  ofs;
    logic [3:0]  rsv [3] = '{4'h3, 4'hE, 4'hF};

    adio_host_regs #(.BASE_ADDR(BASE_DEFAULT)) adio_host_regs_inst (
        .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
        .rdataValid(rdataValid), .convDone(convDone),
        .convResult(convResult), .conv(conv), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe));
    adio_conv_model #(.DLY(10)) adio_conv_model_inst (
        .mclk(mclk), .reset(reset), .conv(conv),
        .convDone(convDone), .convResult(convResult));

    // ==========================================
    // Bus access and comparison
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic [9:0] a, input logic r,
                          input logic [7:0] d);
        @(negedge mclk);
        bus = '{addr: a, rd: r, wr: !r, wdata: d};
        @(negedge mclk);
        bus.rd = 1'b0;
        bus.wr = 1'b0;
        st = rdata;
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        access(BASE_DEFAULT | {6'h00, o}, 1'b0, d);
    endtask
    task automatic rd(input logic [3:0] o, input logic [7:0] exp,
                      input string what);
        access(BASE_DEFAULT | {6'h00, o}, 1'b1, 8'h00);
        check({what, " valid"}, 16'h0001, {15'h0000, rdataValid});
        check(what, {8'h00, exp}, {8'h00, st});
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Clock, watchdog and tests
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        n_fail = 0;
        samples_checked = 0;
        reset = 1'b1;
        bus = '0;
        pinIn = 16'h5A96;
        expInt = 1'b0;
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        check("oe after reset", 16'h0000, pinOe);
        rd(4'h2, 8'h01, "status idle");
        for (int p = 0; p < 2; p++) begin
            ofs = 4'(4 + 2 * p);
            wr(ofs, 8'hA5);
            wr(ofs + 4'h1, 8'h3C);
            rd(ofs, 8'hA5, "direction");
            rd(ofs + 4'h1, 8'h24 | (pinIn[8*p +: 8] & 8'h5A), "data");
            check("pin oe", 16'h00A5, 16'(pinOe[8*p +: 8]));
            check("pin out", 16'h003C, 16'(pinOut[8*p +: 8]));
        end
        access(10'h314, 1'b0, 8'hFF);
        access(10'h314, 1'b1, 8'h00);
        check("off window", 16'h0000, {15'h0000, rdataValid});
        rd(4'h4, 8'hA5, "direction kept");
        for (int c = 0; c < 8; c++) begin
            ctl = {c[1:0], c[0], c[2:1], c[2:0]};
            wr(4'h0, ctl);
            rd(4'h2, 8'h01, "status busy");
            for (int n = 0; n < 40 && st !== 8'h00; n++)
                access(BASE_DEFAULT | 10'h002, 1'b1, 8'h00);
            check("status done", 16'h0000, {8'h00, st});
            if (!ctl[7]) expInt = ctl[6];
            rd(4'h0, {5'h00, ctl[2:0]}, "result low");
            rd(4'h1, {5'h01, ctl[2:0]}, "result high");
            check("power", {13'h0000, expInt, ctl[7:6] == 2'h2,
                  ctl[7:6] == 2'h3}, {13'h0000, conv.internalClock,
                  conv.standbyPowerdown, conv.fullPowerdown});
            check("fields", {10'h000, ctl[5:0]}, {10'h000,
                  conv.externalAcq, conv.span, conv.channel});
        end
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00, "status kept");
        foreach (rsv[i]) begin
            wr(rsv[i], 8'hFF);
            rd(rsv[i], 8'h00, "reserved");
        end
        give_verdict();
    end
endmodule // tb_adio_host_regs
`default_nettype wire
